//--- hw/osctrm_top.sv
// Purpose: Trim register driving the internal oscillator correction code
// Assumes: Single-cycle processor reads and writes on clk_sys_in
// Notes:   Read data is registered, valid one clock after the read strobe
`timescale 1ns/1ps

module osctrm_top
(
	input  wire logic                   clk_sys_in,
	input  wire logic                   rstn_in,
	input  wire osctrm_pkg::osctrm_bus_s bus_in,
	output logic [7:0]                  rdata_out,
	output logic [5:0]                  trim_code_out
);

	// ==========================================================
	// Decode
	// The bus runs on this clock, so no synchroniser sits in front of it.
	// Only one address is decoded; everything else is silently ignored.
	logic [osctrm_pkg::TRIM_W-1:0] trim_code;
	logic [osctrm_pkg::DATA_W-1:0] rdata;
	wire                           hit;
	wire                           wr_hit;
	wire                           rd_hit;
	wire                           wr_miss;
	wire                           rd_miss;
	wire [osctrm_pkg::TRIM_W-1:0] wr_code;
	wire [osctrm_pkg::DATA_W-1:0] read_word;
	wire [osctrm_pkg::DATA_W-1:0] next_rdata;

	assign hit     = (bus_in.addr == osctrm_pkg::CLOCK_TRIM_CONTROL_ADDR);
	assign wr_hit  = hit && bus_in.wr;
	assign rd_hit  = hit && bus_in.rd;
	assign wr_miss = !hit && bus_in.wr;
	assign rd_miss = !hit && bus_in.rd;

	// Upper two bits are dropped on write and read back as zero
	assign wr_code    = bus_in.wdata[osctrm_pkg::TRIM_W-1:0];
	assign read_word  = {osctrm_pkg::UPPER_READ_VALUE, trim_code};

	// Idle value between reads keeps a stale byte off the bus
	assign next_rdata = rd_hit ? read_word : osctrm_pkg::RDATA_IDLE;

	// ==========================================================
	// Trim register
	// The code is a plain unsigned index: each step is one eighth percent,
	// zero is the most negative setting, so the oscillator sees it directly.
	// No clamping or signed offset is applied here; software owns the loop.
	// One cell per code bit, each reset to its own slice of the midpoint.
	genvar bit_idx;
	generate
		for (bit_idx = 0; bit_idx < osctrm_pkg::TRIM_W; bit_idx++)
		begin : g_trim_bit
			osctrm_trim_bit
			#(
				.RESET_BIT (osctrm_pkg::TRIM_MIDPOINT[bit_idx])
			)
			u_cell
			(
				.clk_sys_in (clk_sys_in),
				.rstn_in    (rstn_in),
				.load_in    (wr_hit),
				.d_in       (wr_code[bit_idx]),
				.q_out      (trim_code[bit_idx])
			);
		end
	endgenerate

	// ==========================================================
	// Read data
	// Registered so the output comes from a flop; costs one clock of latency.
	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rdata <= osctrm_pkg::RDATA_IDLE;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Outputs
	// Both are plain flop outputs; the oscillator sees no decode glitches.
	assign trim_code_out = trim_code;
	assign rdata_out     = rdata;

	// ==========================================================
	// Checks
	a_write_reaches_trim: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		wr_hit |=> trim_code_out == $past(wr_code))
		else $error("trim output did not follow write");

	a_trim_holds_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!wr_hit |=> $stable(trim_code_out))
		else $error("trim changed without write");

	a_read_upper_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		rd_hit |=> rdata_out == {osctrm_pkg::UPPER_READ_VALUE, $past(trim_code_out)})
		else $error("read value wrong");

	a_reset_midpoint: assert property (@(posedge clk_sys_in)
		$rose(rstn_in) |-> trim_code_out == osctrm_pkg::TRIM_MIDPOINT)
		else $error("reset code not midpoint");

	a_read_idle_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!rd_hit |=> rdata_out == osctrm_pkg::RDATA_IDLE)
		else $error("read data not idle without read");

	a_miss_write_ignored: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		wr_miss |=> $stable(trim_code_out))
		else $error("write to other address changed trim");

	a_miss_read_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		rd_miss |=> rdata_out == osctrm_pkg::RDATA_IDLE)
		else $error("read of other address returned data");

	a_rdata_upper_clear: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		rdata_out[osctrm_pkg::DATA_W-1:osctrm_pkg::TRIM_W] == osctrm_pkg::UPPER_READ_VALUE)
		else $error("read data upper bits set");
endmodule

// ==========================================================
// Trim code bit cell
// Holds one bit of the trim code; loads on a decoded write.
module osctrm_trim_bit
#(
	parameter logic RESET_BIT = 1'h0
)
(
	input  wire logic clk_sys_in,
	input  wire logic rstn_in,
	input  wire logic load_in,
	input  wire logic d_in,
	output logic      q_out
);

	logic bit_q;
	wire  next_bit_q;

	assign next_bit_q = load_in ? d_in : bit_q;

	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			bit_q <= RESET_BIT;
		end
		else
		begin
			bit_q <= next_bit_q;
		end
	end

	assign q_out = bit_q;
endmodule

//--- shared/osctrm_pkg.sv
// Purpose: Constants and carrier types for the oscillator trim control block
// Assumes: 8-bit processor data bus, 16-bit memory address
// Notes:   One register, trim code in the low six bits
package osctrm_pkg;
	// ==========================================================
	// Register map
	localparam logic [15:0] CLOCK_TRIM_CONTROL_ADDR = 16'hFFED;
	localparam logic [7:0]  CLOCK_TRIM_RESET        = 8'h20;
	localparam int          TRIM_W                  = 6;
	localparam int          DATA_W                  = 8;
	localparam logic [5:0]  TRIM_MIDPOINT           = 6'h20;
	localparam logic [1:0]  UPPER_READ_VALUE        = 2'h0;
	localparam logic [7:0]  RDATA_IDLE              = 8'h00;
	// Step size in thousandths of a percent per code
	localparam int          TRIM_STEP_MILLIPCT      = 125;
	localparam int          TRIM_MIN_MILLIPCT       = -4000;

	// ==========================================================
	// Processor access carrier
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} osctrm_bus_s;
endpackage

//--- verif/osctrm_osc.sv
// Purpose: Oscillator trim input model
// Assumes: Linear trim law
// Notes:   Offset in thousandths of a percent
`timescale 1ns/1ps
module osctrm_osc
#(
	parameter int NATIVE_ERR_MILLIPCT = 750
)
(
	input  wire logic [5:0] trim_in,
	output int              offset_out,
	output int              frame_count_out
);
	// Cycles of a 6 MHz clock in one 1 ms frame
	localparam int NOMINAL_CYCLES = 6000;
	localparam int MILLIPCT_FULL  = 100000;
	assign offset_out = osctrm_pkg::TRIM_MIN_MILLIPCT + osctrm_pkg::TRIM_STEP_MILLIPCT * int'(trim_in);
	// One frame trigger per millisecond; the counter sees every cycle in it
	assign frame_count_out = NOMINAL_CYCLES
		+ (NOMINAL_CYCLES * (NATIVE_ERR_MILLIPCT + offset_out)) / MILLIPCT_FULL;
endmodule

//--- verif/osctrm_top_bench.sv
// Purpose: Bench for the trim register
// Assumes: One-cycle strobes, answer one clock later
// Notes:   Offset judged through the oscillator model
`timescale 1ns/1ps
module osctrm_top_bench;
	logic                    clk_sys_in = 0;
	logic                    rstn_in = 0;
	osctrm_pkg::osctrm_bus_s b = '0;
	logic [7:0]              rd;
	logic [5:0]              tc;
	int                      off, mismatches = 0, checked = 0;
	int                      frame_count;
	localparam int           FRAME_NOMINAL = 6000;
	localparam int           FRAME_TOL     = 15;
	localparam int           MILLIPCT_FULL = 100000;
	localparam int           WATCHDOG      = 3000;
	always #25 clk_sys_in = ~clk_sys_in;
	osctrm_top dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus_in(b), .rdata_out(rd), .trim_code_out(tc));
	osctrm_osc osc (.trim_in(tc), .offset_out(off), .frame_count_out(frame_count));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			$display("BAD %0t got %h exp %h", $time, got, exp);
			mismatches++;
		end
	endtask
	// Strobe for one clock; answer sampled just after the next edge
	task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
		@(posedge clk_sys_in);
		b <= '{a, d, w, !w};
		@(posedge clk_sys_in);
		b <= '0;
		#1;
	endtask
	task automatic stop_test;
		if (mismatches == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic test_default;
		chk({10'h000, tc}, 16'h0020);
		acc(16'hFFED, 8'h00, 0);
		chk({8'h00, rd}, 16'h0020);
		chk(off[15:0], 16'h0000);
	endtask
	task automatic test_write_read;
		acc(16'hFFED, 8'hFF, 1);
		chk({10'h000, tc}, 16'h003F);
		chk(off[15:0], 16'h0F23);
		acc(16'hFFEC, 8'h15, 1);
		chk({10'h000, tc}, 16'h003F);
		acc(16'hFFED, 8'h00, 0);
		chk({8'h00, rd}, 16'h003F);
		@(posedge clk_sys_in);
		#1;
		chk({8'h00, rd}, 16'h0000);
		acc(16'hFFEC, 8'h00, 0);
		chk({8'h00, rd}, 16'h0000);
	endtask
	task automatic test_steps;
		acc(16'hFFED, 8'h21, 1);
		chk(off[15:0], 16'h007D);
		acc(16'hFFED, 8'h00, 1);
		chk(off[15:0], 16'hF060);
	endtask
	task automatic test_mid_reset;
		acc(16'hFFED, 8'h05, 1);
		@(posedge clk_sys_in);
		rstn_in <= 1'h0;
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk({10'h000, tc}, 16'h0020);
		@(posedge clk_sys_in);
		rstn_in <= 1'h1;
		acc(16'hFFED, 8'h00, 0);
		chk({8'h00, rd}, 16'h0020);
	endtask
	// Software correction loop run twice from the reset code
	task automatic test_correction;
		int code;
		int steps;
		for (int pass = 0; pass < 2; pass++)
		begin
			acc(16'hFFED, 8'h00, 0);
			code  = int'(rd[5:0]);
			steps = (((frame_count - FRAME_NOMINAL) * MILLIPCT_FULL) / FRAME_NOMINAL)
				/ osctrm_pkg::TRIM_STEP_MILLIPCT;
			acc(16'hFFED, 8'(code - steps), 1);
		end
		chk({10'h000, tc}, 16'h001A);
		chk({15'h0000, (frame_count >= FRAME_NOMINAL - FRAME_TOL) && (frame_count <= FRAME_NOMINAL + FRAME_TOL)}, 16'h0001);
	endtask
	initial
	begin
		repeat (WATCHDOG) @(posedge clk_sys_in);
		mismatches++;
		stop_test;
	end
	initial
	begin
		repeat (4) @(posedge clk_sys_in);
		rstn_in <= 1;
		test_default;
		test_write_read;
		test_steps;
		test_mid_reset;
		test_correction;
		stop_test;
	end
endmodule
